// ==== core/dbg_pkg.sv ====
// Shared constants and carrier types for the debug-register unit.
package dbg_pkg;

  // Highest number of breakpoints the unit can hold.
  localparam int          MAX_BP          = 4;

  // Debug register numbers as used by the move instructions.
  localparam logic [2:0]  IDX_RSVD_A      = 3'h4;
  localparam logic [2:0]  IDX_RSVD_B      = 3'h5;
  localparam logic [2:0]  IDX_STATUS      = 3'h6;
  localparam logic [2:0]  IDX_CONTROL     = 3'h7;
  localparam logic [2:0]  IDX_ALIAS_BIT   = 3'h2;

  // Field positions in the status register.
  localparam int          ST_HIT_LSB      = 0;
  localparam int          ST_ACCESS_DET   = 13;
  localparam int          ST_SINGLE_STEP  = 14;
  localparam int          ST_TASK_SWITCH  = 15;

  // Field positions in the control register.
  localparam int          CTL_GEN_DETECT  = 13;
  localparam int          CTL_TYPE_LSB    = 16;
  localparam int          CTL_SIZE_LSB    = 18;
  localparam int          CTL_STRIDE      = 4;

  // Values after reset.
  localparam logic [31:0] STATUS_RST      = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RST     = 32'h0000_0000;
  localparam logic [31:0] ADDR_RST        = 32'h0000_0000;

  // Access-type codes of a breakpoint.
  typedef enum logic [1:0] {
    TYPE_EXEC  = 2'h0,
    TYPE_WRITE = 2'h1,
    TYPE_IO    = 2'h2,
    TYPE_DATA  = 2'h3
  } access_type_t;

  // Length codes of a breakpoint.
  typedef enum logic [1:0] {
    SIZE_1 = 2'h0,
    SIZE_2 = 2'h1,
    SIZE_8 = 2'h2,
    SIZE_4 = 2'h3
  } size_code_t;

  // Kind of access the pipeline reports.
  typedef enum logic [1:0] {
    KIND_FETCH = 2'h0,
    KIND_WRITE = 2'h1,
    KIND_READ  = 2'h2,
    KIND_IO    = 2'h3
  } acc_kind_t;

  // Move to or from a debug register.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  idx;
    logic [31:0] wdata;
  } mov_req_t;

  // One linear memory, fetch or I/O access; lg_bytes is log2 of its size.
  typedef struct packed {
    logic        valid;
    acc_kind_t   kind;
    logic [31:0] addr;
    logic [1:0]  lg_bytes;
  } access_t;

  // Operating mode of the processor.
  typedef struct packed {
    logic        real_mode;
    logic        system_mgmt_mode;
    logic [1:0]  current_privilege;
    logic        extension_switch;
  } mode_t;

  // Per-instruction events from the retire stage.
  typedef struct packed {
    logic        valid;
    logic        single_step_trap;
    logic        resume_suppress;
    logic        task_switch;
    logic        task_trap;
    logic        breakpoint_instr;
  } retire_t;

endpackage : dbg_pkg

// ==== core/dbg_access_check.sv ====
// Privilege and reserved-slot decode for debug register moves.
module dbg_access_check
  import dbg_pkg::*;
(
  input  wire mode_t      mode,
  input  wire mov_req_t   req,
  output logic            allowed,
  output logic            prot_fault,
  output logic            inv_fault,
  output logic [2:0]      eff_idx
);

  logic privileged;
  logic reserved;

  assign privileged = mode.real_mode | mode.system_mgmt_mode
                    | (mode.current_privilege == 2'h0);
  assign reserved   = (req.idx == IDX_RSVD_A) | (req.idx == IDX_RSVD_B);
  assign prot_fault = req.valid & ~privileged;
  assign inv_fault  = req.valid & privileged & mode.extension_switch
                    & reserved;
  assign allowed    = req.valid & ~prot_fault & ~inv_fault;
  assign eff_idx    = (reserved & ~mode.extension_switch)
                    ? (req.idx | IDX_ALIAS_BIT) : req.idx;

endmodule : dbg_access_check

// ==== core/dbg_bp_match.sv ====
// Address, length and access-type comparison for one breakpoint.
module dbg_bp_match
  import dbg_pkg::*;
#(
  parameter bit ALLOW_8BYTE = 1'b1
) (
  input  wire logic [31:0] bp_addr,
  input  wire logic [1:0]  type_code,
  input  wire logic [1:0]  size_code,
  input  wire logic        ext_on,
  input  wire logic        resume,
  input  wire access_t     acc,
  output logic             hit
);

  logic [31:0] bmask;
  logic [31:0] amask;
  logic        size_ok;
  logic        overlap;
  logic        type_ok;
  logic [32:0] base;
  logic [32:0] last;
  logic [32:0] alast;

  always_comb begin
    bmask   = 32'h0000_0000;
    size_ok = 1'b1;
    unique case (size_code_t'(size_code))
      SIZE_1: bmask = 32'h0000_0000;
      SIZE_2: bmask = 32'h0000_0001;
      SIZE_4: bmask = 32'h0000_0003;
      SIZE_8: begin
        bmask   = 32'h0000_0007;
        size_ok = ALLOW_8BYTE;
      end
    endcase
    unique case (acc.lg_bytes)
      2'h0: amask = 32'h0000_0000;
      2'h1: amask = 32'h0000_0001;
      2'h2: amask = 32'h0000_0003;
      2'h3: amask = 32'h0000_0007;
    endcase
  end

  // linear address compare.
  // Low address bits are masked, so unaligned settings are forced aligned.
  assign base    = {1'b0, bp_addr & ~bmask};
  assign last    = {1'b0, bp_addr | bmask};
  assign alast   = {1'b0, acc.addr} + {1'b0, amask};
  assign overlap = ({1'b0, acc.addr} <= last) & (base <= alast);

  always_comb begin
    type_ok = 1'b0;
    unique case (access_type_t'(type_code))
      TYPE_EXEC:  type_ok = (acc.kind == KIND_FETCH) & ~resume
                          & (acc.addr == bp_addr);
      TYPE_WRITE: type_ok = (acc.kind == KIND_WRITE) & overlap;
      TYPE_IO:    type_ok = ext_on & (acc.kind == KIND_IO) & overlap;
      TYPE_DATA:  type_ok = ((acc.kind == KIND_WRITE)
                          | (acc.kind == KIND_READ)) & overlap;
    endcase
  end

  assign hit = acc.valid & size_ok & type_ok;

endmodule : dbg_bp_match

// ==== core/dbg_unit.sv ====
// Debug-register unit: breakpoint registers, status, control and traps.

// Summary of operation
// - Eight debug registers reached by moves.
// - Moves need real, mgmt or privilege zero.
// - One to four independent breakpoints.
// - Breakpoints cover 1, 2, 4, 8 bytes.
// - Address registers compare linear addresses.
// - Reserved slots fault when extensions on.
// - Reserved slots alias status and control.
// - Status changes on debug exceptions and on moves.
// - Hit bits record conditions, enabled or not.
// - Access-detect bit, armed by general detect.
// - Single-step bit, highest debug priority.
// - Task-switch bit from task trap flag.
// - Hardware clears only the hit bits.
// - Step trap after each instruction.
// - Resume flag suppresses repeat instruction traps.
// - Breakpoint instruction raises breakpoint trap.
// - Matching enabled access raises debug trap.
// - Local enables; cleared on task switch.
// - Access-type codes select break condition.
// - Length codes select byte count.
// - General detect cleared on handler entry.
module dbg_unit
  import dbg_pkg::*;
#(
  parameter int NUM_BP      = MAX_BP,
  parameter bit ALLOW_8BYTE = 1'b1
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire mode_t       MODE,
  input  wire mov_req_t    MOV_REQ,
  input  wire access_t     ACCESS,
  input  wire retire_t     RETIRE,
  output logic [31:0]      RDATA,
  output logic             MOV_DONE,
  output logic             PROT_FAULT,
  output logic             INV_OP_FAULT,
  output logic             DEBUG_TRAP,
  output logic             BREAKPOINT_TRAP,
  output logic [31:0]      STATUS_VALUE,
  output logic [31:0]      CONTROL_VALUE
);

  // The whole state of the unit; every output is a field of it.
  typedef struct packed {
    logic [NUM_BP-1:0][31:0] bp_addr;
    logic [31:0]             status;
    logic [31:0]             control;
    logic [31:0]             rdata;
    logic                    mov_done;
    logic                    prot_fault;
    logic                    inv_fault;
    logic                    dbg_trap;
    logic                    bp_trap;
  } state_t;

  state_t q;
  state_t d;

  // Decoded move request.
  logic              mov_allowed;
  logic              mov_gp;
  logic              mov_ud;
  logic [2:0]        mov_idx;

  // Per-breakpoint comparison results and enables.
  logic [NUM_BP-1:0] bp_hit;
  logic [NUM_BP-1:0] bp_enabled;
  logic [NUM_BP-1:0] bp_fire;

  // Events that feed one debug exception.
  logic              gd_trip;
  logic              step_ev;
  logic              task_ev;
  logic              take_exc;
  logic              mov_exec;

  // Privilege, reserved-slot and alias decode of the move request.
  dbg_access_check u_check (
    .mode       (MODE),
    .req        (MOV_REQ),
    .allowed    (mov_allowed),
    .prot_fault (mov_gp),
    .inv_fault  (mov_ud),
    .eff_idx    (mov_idx)
  );

  // per-breakpoint comparators.
  // Each comparator reads its own address and its own control fields.
  for (genvar i = 0; i < NUM_BP; i++) begin : g_bp
    dbg_bp_match #(
      .ALLOW_8BYTE (ALLOW_8BYTE)
    ) u_match (
      .bp_addr   (q.bp_addr[i]),
      .type_code (q.control[CTL_TYPE_LSB + CTL_STRIDE*i +: 2]),
      .size_code (q.control[CTL_SIZE_LSB + CTL_STRIDE*i +: 2]),
      .ext_on    (MODE.extension_switch),
      .resume    (RETIRE.resume_suppress),
      .acc       (ACCESS),
      .hit       (bp_hit[i])
    );
    assign bp_enabled[i] = q.control[2*i] | q.control[2*i+1];
  end

  assign bp_fire  = bp_hit & bp_enabled;

  // general detect on move.
  // Any permitted move while the detect bit is set traps before it runs,
  // so the register file is left untouched by that move.
  assign gd_trip  = mov_allowed & q.control[CTL_GEN_DETECT];
  assign mov_exec = mov_allowed & ~gd_trip;

  assign step_ev  = RETIRE.valid & RETIRE.single_step_trap;

  assign task_ev  = RETIRE.task_switch & RETIRE.task_trap;

  // one merged exception.
  // All sources of this cycle are folded into a single exception event.
  assign take_exc = (|bp_fire) | gd_trip | step_ev | task_ev;

  // Next-state logic for the whole unit.
  always_comb begin
    d            = q;
    d.mov_done   = 1'b0;
    d.prot_fault = 1'b0;
    d.inv_fault  = 1'b0;
    d.dbg_trap   = 1'b0;
    d.bp_trap    = 1'b0;

    d.prot_fault = mov_gp;
    d.inv_fault  = mov_ud;

    // move to or from register.
    // Reads capture the old value; a move that trips general detect
    // neither reads nor writes and completes as an exception instead.
    if (mov_exec) begin
      d.mov_done = 1'b1;
      if (MOV_REQ.write) begin
        d.rdata = q.rdata;
        unique case (mov_idx)
          IDX_STATUS:  d.status  = MOV_REQ.wdata;
          IDX_CONTROL: d.control = MOV_REQ.wdata;
          default: begin
            for (int k = 0; k < NUM_BP; k++) begin
              if (mov_idx == 3'(k)) begin
                d.bp_addr[k] = MOV_REQ.wdata;
              end
            end
          end
        endcase
      end else begin
        d.rdata = 32'h0000_0000;
        unique case (mov_idx)
          IDX_STATUS:  d.rdata = q.status;
          IDX_CONTROL: d.rdata = q.control;
          default: begin
            for (int k = 0; k < NUM_BP; k++) begin
              if (mov_idx == 3'(k)) begin
                d.rdata = q.bp_addr[k];
              end
            end
          end
        endcase
      end
    end

    // task switch clears locals.
    // Applied after the software write so that hardware wins a collision.
    if (RETIRE.task_switch) begin
      for (int k = 0; k < NUM_BP; k++) begin
        d.control[2*k] = 1'b0;
      end
    end

    // status updates on exception.
    // Outside an exception the status register only moves by software.
    if (take_exc) begin
      d.dbg_trap = 1'b1;
      // only hit bits may clear.
      // The hit field is rewritten from this event; other flags only set,
      // so a software clear in the same cycle loses to a new event.
      d.status[ST_HIT_LSB +: NUM_BP] = bp_hit;
      if (gd_trip) begin
        d.status[ST_ACCESS_DET] = 1'b1;
      end
      if (step_ev) begin
        d.status[ST_SINGLE_STEP] = 1'b1;
      end
      if (task_ev) begin
        d.status[ST_TASK_SWITCH] = 1'b1;
      end
      d.control[CTL_GEN_DETECT] = 1'b0;
    end

    d.bp_trap = RETIRE.valid & RETIRE.breakpoint_instr;
  end

  // State register; constants only under reset.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int k = 0; k < NUM_BP; k++) begin
        q.bp_addr[k] <= ADDR_RST;
      end
      q.status     <= STATUS_RST;
      q.control    <= CONTROL_RST;
      q.rdata      <= 32'h0000_0000;
      q.mov_done   <= 1'b0;
      q.prot_fault <= 1'b0;
      q.inv_fault  <= 1'b0;
      q.dbg_trap   <= 1'b0;
      q.bp_trap    <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state register.
  assign RDATA           = q.rdata;
  assign MOV_DONE        = q.mov_done;
  assign PROT_FAULT      = q.prot_fault;
  assign INV_OP_FAULT    = q.inv_fault;
  assign DEBUG_TRAP      = q.dbg_trap;
  assign BREAKPOINT_TRAP = q.bp_trap;
  assign STATUS_VALUE    = q.status;
  assign CONTROL_VALUE   = q.control;

endmodule : dbg_unit

// ==== tb/dbg_unit_sva.sv ====
// Concurrent checks of the debug-register unit, bound to its top module.
module dbg_unit_sva
  import dbg_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RESETN,
  input wire mode_t       MODE,
  input wire mov_req_t    MOV_REQ,
  input wire retire_t     RETIRE,
  input wire logic        MOV_DONE,
  input wire logic        PROT_FAULT,
  input wire logic        INV_OP_FAULT,
  input wire logic        DEBUG_TRAP,
  input wire logic        BREAKPOINT_TRAP,
  input wire logic [31:0] STATUS_VALUE,
  input wire logic [31:0] CONTROL_VALUE
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // Move qualifiers shared by the checks below.
  logic priv;
  logic rsvd;
  logic mv;
  assign priv = MODE.real_mode | MODE.system_mgmt_mode |
                (MODE.current_privilege == 2'h0);
  assign rsvd = MODE.extension_switch & (MOV_REQ.idx[2:1] == 2'h2);
  assign mv   = MOV_REQ.valid;

  prot_fault_a: assert property (mv && !priv |=> PROT_FAULT && !MOV_DONE)
    else $error("unprivileged move was not refused");
  inv_opcode_a: assert property (mv && priv && rsvd |=> INV_OP_FAULT)
    else $error("reserved slot move did not fault");
  gen_detect_a: assert property (mv && priv && !rsvd && CONTROL_VALUE[13]
    |=> DEBUG_TRAP && STATUS_VALUE[13] && !CONTROL_VALUE[13] && !MOV_DONE)
    else $error("general detect did not trap the move");
  step_trap_a: assert property (RETIRE.valid && RETIRE.single_step_trap
    |=> DEBUG_TRAP && STATUS_VALUE[14])
    else $error("single step did not trap");
  task_trap_a: assert property (RETIRE.task_switch && RETIRE.task_trap
    |=> DEBUG_TRAP && STATUS_VALUE[15])
    else $error("task trap flag did not trap");
  local_clear_a: assert property (RETIRE.task_switch
    |=> (CONTROL_VALUE & 32'h0000_0055) == 32'h0000_0000)
    else $error("local enables survived a task switch");
  bp_instr_a: assert property (RETIRE.valid && RETIRE.breakpoint_instr
    |=> BREAKPOINT_TRAP)
    else $error("breakpoint instruction did not trap");
  status_hold_a: assert property (!DEBUG_TRAP && !MOV_DONE
    |-> $stable(STATUS_VALUE))
    else $error("status changed without an exception");
  sticky_bits_a: assert property (DEBUG_TRAP && !MOV_DONE
    |-> ($past(STATUS_VALUE) & ~STATUS_VALUE & 32'hFFFF_FFF0) == 32'h0)
    else $error("exception cleared a status bit above the hits");

  // Main scenarios: merged event, reserved fault, task trap.
  cover property (DEBUG_TRAP && STATUS_VALUE[14] && STATUS_VALUE[1:0] == 2'h3);
  cover property (INV_OP_FAULT);
  cover property (RETIRE.task_switch ##1 DEBUG_TRAP);
endmodule : dbg_unit_sva

bind dbg_unit dbg_unit_sva chk (.*);

// ==== tb/dbg_pipe_model.sv ====
// Pipeline model that issues moves, accesses and retire events.
module dbg_pipe_model
  import dbg_pkg::*;
(
  input  wire logic CLK,
  output mov_req_t  MOV_REQ,
  output access_t   ACCESS,
  output retire_t   RETIRE
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle at time zero.
  initial begin
    MOV_REQ = '0;
    ACCESS  = '0;
    RETIRE  = '0;
  end

  // One instruction per call; dropped move and access fields are inverted, retire is cleared, so they never
  // keep a stale value that a sloppy decoder could still match.
  task step(input mov_req_t m, input access_t a, input retire_t r);
    @(posedge CLK);
    MOV_REQ <= m;
    ACCESS  <= a;
    RETIRE  <= r;
    @(posedge CLK);
    MOV_REQ <= '{1'b0, ~m.write, ~m.idx, ~m.wdata};
    ACCESS  <= '{1'b0, acc_kind_t'(~a.kind), ~a.addr, ~a.lg_bytes};
    RETIRE  <= '0;
    #1;
  endtask : step

  function automatic logic [3:0] live_hits(logic [31:0] st, logic [31:0] ctl);
    for (int i = 0; i < 4; i++) live_hits[i] = st[i] & |ctl[2*i +: 2];
  endfunction : live_hits
endmodule : dbg_pipe_model

// ==== tb/breakpoint_debug_registers_tb_top.sv ====
// Self-checking bench of the debug-register unit.
module breakpoint_debug_registers_tb_top;
  import dbg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        CLK, RESETN, MOV_DONE, PROT_FAULT, INV_OP_FAULT;
  logic        DEBUG_TRAP, BREAKPOINT_TRAP;
  logic [31:0] RDATA, STATUS_VALUE, CONTROL_VALUE, b, w;
  mode_t       MODE;
  mov_req_t    MOV_REQ;
  access_t     ACCESS;
  retire_t     RETIRE;
  int          n_fail, n_checks;
  logic [4:0]  mt [4] = '{5'h07, 5'h17, 5'h0F, 5'h01};

  dbg_unit uut (.*);
  dbg_pipe_model pipe (.*);

  // Clock of 5 ns.
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task mv(input logic wr, input logic [2:0] i, input logic [31:0] d);
    pipe.step('{1'b1, wr, i, d}, '0, '0);
  endtask : mv

  task ac(input acc_kind_t k, input logic [31:0] a, input retire_t r);
    pipe.step('0, '{1'b1, k, a, 2'h0}, r);
  endtask : ac

  task setm(input logic [4:0] m);
    @(posedge CLK);
    MODE <= mode_t'(m);
  endtask : setm

  // Byte count of a length code.
  function automatic logic [31:0] nbytes(logic [1:0] c);
    return c == 2'h0 ? 32'h1 : c == 2'h1 ? 32'h2 : c == 2'h3 ? 32'h4 : 32'h8;
  endfunction : nbytes

  task final_report;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // Watchdog; the tests need about 0.7 us.
  initial begin
    #20000;
    n_fail++;
    final_report();
  end

  // Main sequence; random addresses come from the fixed seed.
  initial begin
    RESETN = 1'b0;
    MODE   = mode_t'(5'h01);
    void'($urandom(32'h6541));
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    chk(STATUS_VALUE, STATUS_RST);
    chk(CONTROL_VALUE, CONTROL_RST);
    for (int i = 0; i < 4; i++) begin
      w = $urandom;
      mv(1'b1, 3'(i), w);
      mv(1'b0, 3'(i), 32'h0);
      chk(MOV_DONE, 1'b1);
      chk(RDATA, w);
    end
    // Only privilege zero, real mode or management mode may move.
    for (int j = 0; j < 4; j++) begin
      setm(mt[j]);
      mv(1'b1, 3'h0, w);
      chk(PROT_FAULT, j == 0);
    end
    mv(1'b1, 3'h4, w);
    chk(INV_OP_FAULT, 1'b1);
    setm(5'h00);
    mv(1'b1, 3'h5, 32'h0000_0F0A);
    chk(CONTROL_VALUE, 32'h0000_0F0A);
    mv(1'b1, 3'h4, 32'h0000_0F00);
    chk(STATUS_VALUE, 32'h0000_0F00);
    mv(1'b1, 3'h5, 32'h0);
    mv(1'b1, 3'h4, 32'h0);
    setm(5'h01);
    // Fetch breakpoint, then the same fetch while resuming.
    b = $urandom & 32'hFFFF_FFF8;
    mv(1'b1, 3'h0, b);
    mv(1'b1, 3'h7, 32'h1);
    ac(KIND_FETCH, b, '0);
    chk(STATUS_VALUE, 32'h1);
    ac(KIND_FETCH, b, retire_t'(6'h28));
    chk(DEBUG_TRAP, 1'b0);
    // Data breakpoint over every length code, at its last byte and one past it.
    for (int c = 0; c < 4; c++) begin
      mv(1'b1, 3'h1, b);
      mv(1'b1, 3'h7, 32'h0030_0008 | 32'(c) << 22);
      mv(1'b1, 3'h6, 32'h0);
      ac(KIND_READ, b + nbytes(c) - 32'h1, '0);
      chk(STATUS_VALUE, 32'h2);
      ac(KIND_WRITE, b + nbytes(c), '0);
      chk(DEBUG_TRAP, 1'b0);
    end
    mv(1'b1, 3'h7, 32'h0010_0008);
    ac(KIND_READ, b, '0);
    chk(DEBUG_TRAP, 1'b0);
    ac(KIND_WRITE, b, '0);
    chk(DEBUG_TRAP, 1'b1);
    mv(1'b1, 3'h7, 32'h0020_0008);
    ac(KIND_IO, b, '0);
    chk(DEBUG_TRAP, 1'b1);
    // Disabled and enabled hits merge with a step in one event.
    mv(1'b1, 3'h7, 32'h0033_0008);
    mv(1'b1, 3'h6, 32'h0);
    ac(KIND_READ, b, retire_t'(6'h30));
    chk(STATUS_VALUE, 32'h4003);
    chk(pipe.live_hits(STATUS_VALUE, CONTROL_VALUE), 32'h2);
    // Task switches drop local enables; only the trap flag traps.
    mv(1'b1, 3'h7, 32'h9);
    mv(1'b1, 3'h6, 32'h0);
    pipe.step('0, '0, retire_t'(6'h06));
    chk(STATUS_VALUE, 32'h8000);
    chk(CONTROL_VALUE, 32'h8);
    mv(1'b1, 3'h7, 32'h1);
    pipe.step('0, '0, retire_t'(6'h04));
    chk(DEBUG_TRAP, 1'b0);
    chk(CONTROL_VALUE, 32'h0);
    // General detect traps the next move and disarms itself.
    mv(1'b1, 3'h6, 32'h0);
    mv(1'b1, 3'h7, 32'h2000);
    mv(1'b0, 3'h0, 32'h0);
    chk(MOV_DONE, 1'b0);
    chk(STATUS_VALUE, 32'h2000);
    chk(CONTROL_VALUE, 32'h0);
    pipe.step('0, '0, retire_t'(6'h21));
    chk(BREAKPOINT_TRAP, 1'b1);
    chk(STATUS_VALUE, 32'h2000);
    mv(1'b1, 3'h6, 32'h0);
    pipe.step('0, '0, retire_t'(6'h30));
    chk(STATUS_VALUE, 32'h4000);
    final_report();
  end
endmodule : breakpoint_debug_registers_tb_top
